// >>> dv/bridge_far_end.sv
// Far-end model: word and bit clocks, converter, DSP output and coax source
`timescale 1ns/100ps
module bridge_far_end (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [63:0] adc_frame_i,
  input  wire logic [63:0] dsp_frame_i,
  input  wire logic [63:0] coax_frame_i,
  input  wire logic        coax_on_i,
  output logic             word_clock_o = 1'b0,
  output logic             bit_clock_o = 1'b0,
  output logic             adc_data_o = 1'b0,
  output logic             dsp_data_o = 1'b0,
  output logic             coax_o = 1'b0,
  output logic [9:0]       cyc_o = 10'h27f
);
  logic [5:0] s;
  // ----------------------------------------------------------------
  // Ten clocks a slot, 64 slots a frame; lines move on falling edges
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    if (!rst_b_i) begin
      cyc_o = 10'h27f;
    end else begin
      cyc_o = (cyc_o == 10'h27f) ? 10'h000 : cyc_o + 10'h001;
      s = 6'(cyc_o / 10);
      if (cyc_o % 10 == 0) begin
        bit_clock_o = 1'b1;
        word_clock_o = (s < 6'h20);
        adc_data_o = adc_frame_i[63 - s];
        dsp_data_o = dsp_frame_i[63 - s];
        coax_o = coax_o ^ coax_on_i; // Cell start; a stopped line shows a violation
      end else if (cyc_o % 10 == 5) begin
        bit_clock_o = 1'b0;
        coax_o = coax_o ^ (coax_on_i & coax_frame_i[63 - s]); // Mid cell for a one
      end
    end
  end
endmodule

// >>> dv/spdif_audio_format_bridge_test.sv
// Self-checking bench for the audio format bridge and its byte FIFO
`timescale 1ns/100ps
`include "spdif_bridge_cfg.svh"
module spdif_audio_format_bridge_test;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        source_coax = 1'b0;
  logic        analog_out = 1'b1;
  logic        coax_on = 1'b0;
  logic [63:0] adc_frame = '0;
  logic [63:0] dsp_frame = '0;
  logic [63:0] coax_frame = '0;
  logic        wclk, bclk, adc, dsp_out, coax_rx, dsp_in, dac, coax_tx;
  logic [9:0]  cyc;
  logic [15:0] lfsr = 16'h003a;
  int          fails = 0;
  int          n_compared = 0;
  logic        h1 [64];
  logic        h2 [64];
  logic [23:0] seq;

  always #5 clk_i = ~clk_i;

  spdif_audio_format_bridge dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .audio_word_clock_i(wclk),
    .bit_clock_i(bclk), .adc_data_i(adc), .coax_digital_rx_i(coax_rx), .dsp_out_data_i(dsp_out),
    .source_coax_i(source_coax), .analog_out_i(analog_out), .dsp_in_data_o(dsp_in),
    .dac_data_o(dac), .coax_digital_tx_o(coax_tx));
  bridge_far_end far_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .adc_frame_i(adc_frame),
    .dsp_frame_i(dsp_frame), .coax_frame_i(coax_frame), .coax_on_i(coax_on), .word_clock_o(wclk),
    .bit_clock_o(bclk), .adc_data_o(adc), .dsp_data_o(dsp_out), .coax_o(coax_rx), .cyc_o(cyc));

  // ----------------------------------------------------------------
  // Helpers: random source, comparison, bounded waits, verdict
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic rand64(output logic [63:0] v);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      v = {v[47:0], lfsr};
    end
  endtask
  // A reversed byte leaves with its first-received bit last, so windows are rotations of b
  function automatic logic rot_match(logic [23:0] q, logic [7:0] b);
    logic hit;
    hit = 1'b0;
    for (int w = 0; w < 16; w++)
      for (int r = 0; r < 8; r++)
        if (q[w +: 8] === 8'({b, b} >> r)) hit = 1'b1;
    return hit;
  endfunction
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Outputs settle on the third rising edge after a slot edge, so sample 1 ns past the falling edge
  task automatic wait_cyc(int t);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      #1;
      n++;
    end while (cyc !== 10'(t) && n < 1000);
    if (cyc !== 10'(t)) begin
      fails++;
      report_and_stop();
    end
  endtask
  // Converter frames; flags are judged only once two whole frames have passed
  task automatic conv_frames(logic viol, logic perr);
    for (int k = 0; k < 3; k++) begin
      wait_cyc(639);
      rand64(adc_frame);
      rand64(dsp_frame);
      for (int s = 0; s < 64; s++) begin
        wait_cyc(s * 10 + 8);
        if (s == 61 && k > 1) check("viol_flag", dsp_in, viol);
        else if (s == 62 && k > 1 && coax_on) check("perr_flag", dsp_in, perr);
        else if (s < 61 || s == 63) check("adc_pass", dsp_in, adc_frame[63 - s]);
        check("dac_bypass", dac, dsp_frame[63 - s]);
        check("tx_quiet", coax_tx, 1'b0);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk_i);
    rst_b_i <= 1'b1;
    conv_frames(1'b1, 1'b0);
    coax_on = 1'b1;
    coax_frame = {8{8'h0b}};
    conv_frames(1'b0, 1'b0);
    coax_frame = 64'h0b0b_0b0a_0b0b_0b0b;
    conv_frames(1'b0, 1'b1);
    // Coax input with a byte that is not a rotation of its own reverse
    coax_frame = {8{8'h0b}};
    source_coax = 1'b1;
    repeat (2) wait_cyc(639);
    for (int s = 0; s < 24; s++) begin
      wait_cyc(s * 10 + 8);
      seq[s] = dsp_in;
    end
    check("rx_reversed", rot_match(seq, 8'h0b), 1'b1);
    // Digital output: block start in slots 57 to 60 of the DSP stream
    analog_out = 1'b0;
    dsp_frame = {8{8'h0b}} | 64'h0000_0000_0000_0078;
    for (int k = 0; k < 2; k++)
      for (int s = 0; s < 64; s++) begin
        wait_cyc(s * 10 + 6);
        h1[s] = coax_tx;
        wait_cyc((s * 10 + 11) % 640);
        h2[s] = coax_tx;
        check("dac_idle", dac, 1'b0);
      end
    for (int i = 0; i < 4; i++) begin
      check("pre_right", {h1[37 + i], h2[37 + i]}, 2'(`PRE_PAT_RIGHT >> (6 - 2 * i)));
      check("pre_left", {h1[5 + i], h2[5 + i]}, 2'(`PRE_PAT_LEFT >> (6 - 2 * i)));
    end
    for (int s = 42; s < 64; s++) check("cell_start", h1[s] ^ h2[s - 1], 1'b1);
    for (int s = 10; s < 37; s++) check("cell_start", h1[s] ^ h2[s - 1], 1'b1);
    for (int i = 0; i < 23; i++) seq[i] = h1[41 + i] ^ h2[41 + i];
    seq[23] = 1'b0;
    check("tx_swapped", rot_match(seq, 8'h0b), 1'b1);
    // Random coax bytes through the byte FIFO; the last pass follows a mid-run reset
    for (int j = 0; j < 5; j++) begin
      if (j == 4) begin
        rst_b_i = 1'b0;
        repeat (5) @(negedge clk_i);
        check("reset_dsp_in", dsp_in, 1'b0);
        check("reset_tx", coax_tx, 1'b0);
        check("reset_dac", dac, 1'b0);
        rst_b_i <= 1'b1;
      end else begin
        lfsr = lfsr_next(lfsr);
        coax_frame = {8{lfsr[7:0]}};
      end
      repeat (3) wait_cyc(639);
      for (int s = 0; s < 24; s++) begin
        wait_cyc(s * 10 + 8);
        seq[s] = dsp_in;
      end
      check("fifo_data", rot_match(seq, lfsr[7:0]), 1'b1);
    end
    // Stopped line: every cell reads as zero, so only empty groups reach the DSP
    coax_on = 1'b0;
    repeat (2) wait_cyc(639);
    for (int s = 0; s < 64; s++) begin
      wait_cyc(s * 10 + 8);
      check("rx_idle", dsp_in, 1'b0);
    end
    report_and_stop();
  end
endmodule

// >>> verilog/spdif_audio_format_bridge.sv
// Audio format bridge between converters, coaxial S/PDIF line and DSP serial ports
`timescale 1ns/100ps
`include "spdif_bridge_cfg.svh"

// ----------------------------------------------------------------------------
// Byte FIFO between demodulator and DSP serialiser
// ----------------------------------------------------------------------------
module bridge_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_WORDS
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Handshakes are combinational, storage is flops
  assign in_ready_o  = (count != (AW+1)'(DEPTH)); // Full compare needs the extra count bit
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (count == (AW+1)'(DEPTH)) |-> !in_ready_o) else $error("fifo accepts while full");
endmodule

// Notes on behaviour
// - With the converter as source its data is forwarded unchanged apart from two status bits.
// - Those status bits are the biphase violation in slot 61 and the parity error in slot 62.
// - Coax input is demodulated, gathered in 8-bit groups, bit reversed and sent to the DSP.
// - DSP output data is bit swapped in 8-bit groups and biphase modulated onto the coax output.
// - In analog output mode DSP output goes straight to the DAC and the coax output logic stays idle.
// - Right preamble cells are driven in slots 37 to 40.
// - Right audio follows LSB first from slot 41 through slot 63.
module spdif_audio_format_bridge (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic audio_word_clock_i,
  input  wire logic bit_clock_i,
  input  wire logic adc_data_i,
  input  wire logic coax_digital_rx_i,
  input  wire logic dsp_out_data_i,
  input  wire logic source_coax_i,
  input  wire logic analog_out_i,
  output logic      dsp_in_data_o,
  output logic      dac_data_o,
  output logic      coax_digital_tx_o
);
  logic [`SYNC_WIDTH-1:0] sync_meta;
  logic [`SYNC_WIDTH-1:0] sync;
  logic                   wclk_prev;
  logic                   bclk_prev;
  logic                   rx_prev;
  logic                   wclk_rise;
  logic                   bclk_rise;
  logic                   bclk_fall;
  logic                   rx_edge;
  spdif_bridge_pkg::slot_t  slot;
  spdif_bridge_pkg::slot_t  next_slot;
  spdif_bridge_pkg::source_t src;
  logic [1:0]             trans_cnt;
  logic                   rx_bit;
  logic                   rx_viol;
  logic                   viol_acc;
  logic                   viol_flag;
  logic                   par_acc;
  logic                   perr_acc;
  logic                   perr_flag;
  spdif_bridge_pkg::group_t rx_shift;
  logic [2:0]             rx_cnt;
  logic                   grp_valid;
  logic                   grp_ready;
  spdif_bridge_pkg::group_t fifo_data;
  logic                   fifo_valid;
  logic                   ser_take;
  spdif_bridge_pkg::group_t ser_shift;
  logic [3:0]             ser_cnt;
  spdif_bridge_pkg::group_t tx_shift;
  logic [2:0]             tx_cnt;
  spdif_bridge_pkg::group_t mod_shift;
  logic                   half;
  logic                   in_pre;
  logic                   pre_left;

  // Reverse bit order of one 8-bit group
  function automatic spdif_bridge_pkg::group_t rev8(input spdif_bridge_pkg::group_t g);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = g[7-i];
    end
  endfunction

  // Pick one half cell of a preamble pattern
  function automatic logic pre_cell(input spdif_bridge_pkg::group_t pat, input logic [2:0] idx);
    return pat[idx];
  endfunction

  // ----------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------------
  // All pins are asynchronous to clk_i; only the second stage is read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_meta <= '0;
      sync      <= '0;
    end else begin
      sync_meta <= {analog_out_i, source_coax_i, dsp_out_data_i, coax_digital_rx_i,
                    adc_data_i, bit_clock_i, audio_word_clock_i};
      sync      <= sync_meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wclk_prev <= 1'b0;
      bclk_prev <= 1'b0;
      rx_prev   <= 1'b0;
    end else begin
      wclk_prev <= sync[0];
      bclk_prev <= sync[1];
      rx_prev   <= sync[3];
    end
  end

  assign wclk_rise = sync[0] && !wclk_prev;
  assign bclk_rise = sync[1] && !bclk_prev;
  assign bclk_fall = !sync[1] && bclk_prev;
  assign rx_edge   = sync[3] ^ rx_prev;
  assign src       = sync[5] ? spdif_bridge_pkg::SRC_COAX : spdif_bridge_pkg::SRC_ANALOG;

  // ----------------------------------------------------------------------------
  // Slot counter
  // ----------------------------------------------------------------------------
  // 64 slots wrap naturally in six bits; word clock realigns every frame
  assign next_slot = wclk_rise ? '0 : slot + 1'b1;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slot <= '0;
    end else if (wclk_rise || bclk_rise) begin
      slot <= next_slot;
    end
  end

  chk_slot_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wclk_rise |=> slot == '0) else $error("slot count not restarted by word clock");
  chk_slot_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && !wclk_rise) |=> slot == $past(slot) + 1'b1) else $error("slot did not advance");

  // ----------------------------------------------------------------------------
  // Biphase demodulator
  // ----------------------------------------------------------------------------
  // Two transitions in a cell mean one, one means zero, none is a violation
  assign rx_bit  = (trans_cnt >= 2'd2);
  assign rx_viol = (trans_cnt == 2'd0);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trans_cnt <= '0;
    end else if (bclk_rise) begin
      trans_cnt <= {1'b0, rx_edge};
    end else if (rx_edge && trans_cnt != 2'd3) begin
      trans_cnt <= trans_cnt + 1'b1;
    end
  end

  // Status flags: gathered over a frame, presented for the whole next frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      viol_acc  <= 1'b0;
      viol_flag <= 1'b0;
      par_acc   <= 1'b0;
      perr_acc  <= 1'b0;
      perr_flag <= 1'b0;
    end else if (bclk_rise) begin
      viol_acc <= (viol_acc && !wclk_rise) || rx_viol; // new event wins over frame clear
      par_acc  <= (slot == `SLOT_SUB_END_L || slot == `SLOT_SUB_END_R) ? 1'b0 : par_acc ^ rx_bit;
      perr_acc <= (perr_acc && !wclk_rise) ||
                  ((slot == `SLOT_SUB_END_L || slot == `SLOT_SUB_END_R) && (par_acc ^ rx_bit));
      if (wclk_rise) begin
        viol_flag <= viol_acc;
        perr_flag <= perr_acc;
      end
    end
  end

  // Gather received bits into groups for the FIFO
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_shift  <= '0;
      rx_cnt    <= '0;
      grp_valid <= 1'b0;
    end else begin
      if (grp_valid && grp_ready) grp_valid <= 1'b0;
      if (bclk_rise && src == spdif_bridge_pkg::SRC_COAX) begin
        rx_shift <= {rx_shift[6:0], rx_bit};
        rx_cnt   <= rx_cnt + 1'b1;
        if (rx_cnt == 3'd7) grp_valid <= 1'b1;
      end
    end
  end

  // A full FIFO holds the group back; a further group then overwrites it
  bridge_fifo #(.WIDTH(8), .DEPTH(`FIFO_WORDS)) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (rev8(rx_shift)),
    .in_valid_i  (grp_valid),
    .in_ready_o  (grp_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (ser_take)
  );

  // ----------------------------------------------------------------------------
  // DSP input serialiser
  // ----------------------------------------------------------------------------
  // Reversed group goes out MSB first, so the last received bit leads
  assign ser_take = bclk_rise && (ser_cnt == '0) && (src == spdif_bridge_pkg::SRC_COAX);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ser_shift     <= '0;
      ser_cnt       <= '0;
      dsp_in_data_o <= 1'b0;
    end else if (bclk_rise) begin
      if (src == spdif_bridge_pkg::SRC_ANALOG) begin
        if (next_slot == `SLOT_VIOL) dsp_in_data_o <= viol_flag;
        else if (next_slot == `SLOT_PERR) dsp_in_data_o <= perr_flag;
        else dsp_in_data_o <= sync[2];
      end else if (ser_cnt != '0) begin
        dsp_in_data_o <= ser_shift[7];
        ser_shift     <= {ser_shift[6:0], 1'b0};
        ser_cnt       <= ser_cnt - 1'b1;
      end else if (fifo_valid) begin
        dsp_in_data_o <= fifo_data[7];
        ser_shift     <= {fifo_data[6:0], 1'b0};
        ser_cnt       <= `GROUP_BITS - 1'b1;
      end else begin
        dsp_in_data_o <= 1'b0;
      end
    end
  end

  chk_viol_slot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && !sync[5] && next_slot == 6'd61) |=> dsp_in_data_o == $past(viol_flag))
    else $error("violation flag missing from slot 61");
  chk_perr_slot: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && !sync[5] && next_slot == 6'd62) |=> dsp_in_data_o == $past(perr_flag))
    else $error("parity flag missing from slot 62");
  chk_adc_pass: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && !sync[5] && next_slot < 6'd61) |=> dsp_in_data_o == $past(sync[2]))
    else $error("converter data not forwarded");
  chk_group_push: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && sync[5] && rx_cnt == 3'd7) |=> grp_valid) else $error("group not offered");

  // ----------------------------------------------------------------------------
  // Output side: bypass, bit swap and biphase modulator
  // ----------------------------------------------------------------------------
  // DAC path always follows the DSP stream in analog mode
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dac_data_o <= 1'b0;
    end else begin
      dac_data_o <= sync[6] ? sync[4] : 1'b0;
    end
  end

  // Swap each received group; one group of latency is the price of reversal
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_shift  <= '0;
      tx_cnt    <= '0;
      mod_shift <= '0;
    end else if (bclk_rise && !sync[6]) begin
      tx_shift <= {tx_shift[6:0], sync[4]};
      tx_cnt   <= tx_cnt + 1'b1;
      if (tx_cnt == 3'd7) mod_shift <= rev8({tx_shift[6:0], sync[4]});
      else mod_shift <= {mod_shift[6:0], 1'b0};
    end
  end

  assign pre_left = (next_slot >= `SLOT_PRE_L_FIRST) && (next_slot <= `SLOT_PRE_L_LAST);
  assign in_pre   = pre_left ||
                    ((next_slot >= `SLOT_PRE_R_FIRST) && (next_slot <= `SLOT_PRE_R_LAST));

  // Cell start always toggles; mid cell toggles for a one; preambles are fixed patterns
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      coax_digital_tx_o <= 1'b0;
      half              <= 1'b0;
    end else if (sync[6]) begin
      coax_digital_tx_o <= 1'b0;
      half              <= 1'b0;
    end else if (bclk_rise) begin
      half <= in_pre;
      if (pre_left) coax_digital_tx_o <= pre_cell(`PRE_PAT_LEFT, 3'd7 - {next_slot[1:0] - 2'd1, 1'b0});
      else if (in_pre) coax_digital_tx_o <= pre_cell(`PRE_PAT_RIGHT, 3'd7 - {next_slot[1:0] - 2'd1, 1'b0});
      else coax_digital_tx_o <= !coax_digital_tx_o;
    end else if (bclk_fall) begin
      // Mid cell looks at the current slot; next_slot already points past it here
      if (half) coax_digital_tx_o <= pre_cell((slot <= `SLOT_PRE_L_LAST) ? `PRE_PAT_LEFT : `PRE_PAT_RIGHT,
                                              3'd6 - {slot[1:0] - 2'd1, 1'b0});
      else if (mod_shift[7]) coax_digital_tx_o <= !coax_digital_tx_o;
    end
  end

  chk_dac_bypass: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sync[6] |=> (dac_data_o == $past(sync[4])) && !coax_digital_tx_o)
    else $error("analog mode not bypassing");
  chk_data_cell: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && !sync[6] && next_slot >= 6'd41) |=> coax_digital_tx_o != $past(coax_digital_tx_o))
    else $error("data cell lacks start transition");
  chk_pre_right: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bclk_rise && !sync[6] && next_slot == 6'd37) |=> coax_digital_tx_o == 1'b1)
    else $error("right preamble missing in slot 37");
  cov_coax_group: cover property (@(posedge clk_i) disable iff (!rst_b_i) ser_take && fifo_valid);
  cov_fifo_full: cover property (@(posedge clk_i) disable iff (!rst_b_i) grp_valid && !grp_ready);
  cov_viol_seen: cover property (@(posedge clk_i) disable iff (!rst_b_i) wclk_rise && viol_acc);
endmodule

// >>> verilog/spdif_bridge_cfg.svh
// Slot positions, preamble patterns and frame constants for the audio bridge
`ifndef SPDIF_BRIDGE_CFG_SVH
`define SPDIF_BRIDGE_CFG_SVH
`define SLOTS_PER_FRAME  7'h40
`define SLOT_VIOL        6'h3d
`define SLOT_PERR        6'h3e
`define SLOT_PRE_L_FIRST 6'h05
`define SLOT_PRE_L_LAST  6'h08
`define SLOT_PRE_R_FIRST 6'h25
`define SLOT_PRE_R_LAST  6'h28
`define SLOT_R_DATA0     6'h29
`define SLOT_SUB_END_L   6'h1f
`define SLOT_SUB_END_R   6'h3f
`define PRE_PAT_LEFT     8'he4
`define PRE_PAT_RIGHT    8'he2
`define GROUP_BITS       4'h8
`define FIFO_WORDS       16
`define SYNC_WIDTH       7
`endif

// >>> verilog/spdif_bridge_pkg.sv
// Types shared by the audio bridge
package spdif_bridge_pkg;
  typedef logic [5:0] slot_t;
  typedef logic [7:0] group_t;
  typedef enum logic {SRC_ANALOG, SRC_COAX} source_t;
endpackage
